// File: sldc_pkg.sv
`default_nettype none
package sldc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_INIT_SYNC = 12'h473;
  localparam logic [11:0] IDX_MAIN      = 12'h475;
  localparam logic [11:0] IDX_ERR_ILAS  = 12'h476;
  localparam logic [11:0] IDX_TEST      = 12'h477;
  localparam logic [11:0] IDX_IRQ_STAT  = 12'h4A0;
  localparam logic [11:0] IDX_IRQ_MASK  = 12'h4A1;

  // Main control fields
  localparam int unsigned MAIN_RECEIVER_DISABLE   = 7;
  localparam int unsigned MAIN_REPL_OFF = 6;
  localparam int unsigned MAIN_SRST     = 3;
  localparam int unsigned MAIN_FSYNC    = 2;
  localparam int unsigned MAIN_FRM_REP  = 0;
  // Error and alignment control fields
  localparam int unsigned ERR_QUAL      = 4;
  localparam int unsigned ERR_ALT_SCR   = 3;
  localparam int unsigned ERR_POST_SYNC_BEHAVIOUR_SEL   = 2;
  localparam int unsigned ERR_SKIP_ALIGNMENT_SEQUENCE   = 1;
  localparam int unsigned ERR_FCHK      = 0;
  // Test control field
  localparam int unsigned TEST_PERP     = 7;
  // Lane 0 sync status field
  localparam int unsigned STAT_ILS0     = 0;

  // Reset values and writable bits
  localparam logic [7:0] MAIN_RST       = 8'h01;
  localparam logic [7:0] ERR_ILAS_RST   = 8'h14;
  localparam logic [7:0] TEST_RST       = 8'h00;
  localparam logic [7:0] MAIN_WMASK     = 8'hCD;
  localparam logic [7:0] ERR_ILAS_WMASK = 8'h1F;
  localparam logic [7:0] TEST_WMASK     = 8'h80;

  // Interrupt bits
  localparam int unsigned IRQ_W         = 4;
  localparam int unsigned IRQ_SYNC_LOST = 0;
  localparam int unsigned IRQ_CKS_ERR   = 1;
  localparam int unsigned IRQ_DISP_ERR  = 2;
  localparam int unsigned IRQ_UNEXP_K   = 3;
  localparam logic [IRQ_W-1:0] IRQ_RST  = 4'h0;

  // Control characters (K flag set)
  localparam logic [7:0] CHAR_R = 8'h1C;
  localparam logic [7:0] CHAR_A = 8'h7C;
  localparam logic [7:0] CHAR_Q = 8'h9C;
  localparam logic [7:0] CHAR_K = 8'hBC;
  localparam logic [7:0] CHAR_F = 8'hFC;

  // Counts, octet indices and bit positions
  localparam logic [2:0] CGS_K_COUNT     = 3'h4;
  localparam logic [2:0] ILAS_MF_COUNT   = 3'h4;
  localparam logic [2:0] DISP_LOSS_COUNT = 3'h4;
  localparam logic [3:0] CFG_CKS_IDX     = 4'hD;
  localparam logic [3:0] CFG_SCR_IDX     = 4'h3;
  localparam int unsigned CFG_SCR_BIT    = 7;
  localparam logic [1:0] ALT_SCR_OCTET   = 2'h2;

  typedef struct packed {
    logic [7:0] data;
    logic       is_k;
    logic       nit_err;
    logic       disp_err;
    logic       valid;
  } sldc_rx_t;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } sldc_out_t;

  typedef enum logic [2:0] {
    SLDC_CGS  = 3'b001,
    SLDC_ILAS = 3'b010,
    SLDC_DATA = 3'b100
  } sldc_state_t;

endpackage

`default_nettype wire

// File: sldc_deframer_ctrl.sv
// Behaviour
// RULE1: receiver disable bit stops deframer reception
// RULE2: software changes configuration only during soft reset
// RULE3: substitution-off bit passes /A/ and /F/ unchanged
// RULE4: soft reset bit holds deframer at power-on; here sync_request_out follows the force bit instead of staying low
// RULE5: force bit asserts sync request output
// RULE6: errored frames replaced when replace enable set
// RULE7: qualify bit lets table error mask disparity
// RULE8: alternative start descrambles from user octet two
// RULE9: select zero: disparity error count forces resync
// RULE10: select one: /K/ then non-/R/,/K/ resyncs
// RULE11: skip bit goes straight to user data
// RULE12: multilane links keep skip bit at zero
// RULE13: checksum method: field sum or byte sum
// RULE14: test mode repeats alignment sequence forever
// RULE15: lane 0 initial sync reported read-only
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module sldc_deframer_ctrl (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire sldc_pkg::sldc_rx_t rx_in,
  output sldc_pkg::sldc_out_t    user_out,
  output logic                   sync_request_out,
  output logic                   irq
);

  // Descramble one octet, MSB first, with 1 + x^14 + x^15
  function automatic logic [22:0] sldc_descr(input logic [14:0] h,
                                             input logic [7:0]  b);
    logic [14:0] s;
    logic [7:0]  o;
    s = h;
    o = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      o[i] = b[i] ^ s[13] ^ s[14];
      s    = {s[13:0], b[i]};
    end
    return {o, s};
  endfunction

  // Sum of the link parameter fields held in one configuration octet
  function automatic logic [7:0] sldc_field_sum(input logic [3:0] idx,
                                                input logic [7:0] b);
    logic [7:0] f;
    f = 8'h00;
    unique case (idx)
      4'h0, 4'h4, 4'h6: f = b;
      4'h1: f = 8'(b[7:4]) + 8'(b[3:0]);
      4'h2: f = 8'(b[6]) + 8'(b[5]) + 8'(b[4:0]);
      4'h3, 4'hA: f = 8'(b[7]) + 8'(b[4:0]);
      4'h5: f = 8'(b[4:0]);
      4'h7: f = 8'(b[7:6]) + 8'(b[4:0]);
      4'h8, 4'h9: f = 8'(b[7:5]) + 8'(b[4:0]);
      default: f = 8'h00;
    endcase
    return f;
  endfunction

  // Register file
  logic [7:0]                 ctrl_main;
  logic [7:0]                 ctrl_err;
  logic [7:0]                 ctrl_test;
  logic [sldc_pkg::IRQ_W-1:0] irq_stat;
  logic [sldc_pkg::IRQ_W-1:0] irq_mask;
  logic                       init_sync;

  // Bus slave state
  logic        pend;
  logic        ap_write;
  logic        ap_ok;
  logic [11:0] ap_idx;

  wire acc = hsel & hready & htrans[1];
  wire dec_ok = (haddr[31:14] == 18'h00000) & (haddr[1:0] == 2'h0);
  wire do_wr = pend & ap_write & ap_ok;
  wire wr_main = do_wr & (ap_idx == sldc_pkg::IDX_MAIN);
  wire wr_err  = do_wr & (ap_idx == sldc_pkg::IDX_ERR_ILAS);
  wire wr_test = do_wr & (ap_idx == sldc_pkg::IDX_TEST);
  wire wr_stat = do_wr & (ap_idx == sldc_pkg::IDX_IRQ_STAT);
  wire wr_mask = do_wr & (ap_idx == sldc_pkg::IDX_IRQ_MASK);

  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    if (ap_ok) begin
      unique case (ap_idx)
        sldc_pkg::IDX_INIT_SYNC:
          rd_val[sldc_pkg::STAT_ILS0] = init_sync; // [RULE15]
        sldc_pkg::IDX_MAIN:     rd_val = ctrl_main;
        sldc_pkg::IDX_ERR_ILAS: rd_val = ctrl_err;
        sldc_pkg::IDX_TEST:     rd_val = ctrl_test;
        sldc_pkg::IDX_IRQ_STAT: rd_val = 8'(irq_stat);
        sldc_pkg::IDX_IRQ_MASK: rd_val = 8'(irq_mask);
        default:                rd_val = 8'h00;
      endcase
    end
  end

  // Control bits
  wire receiver_disable    = ctrl_main[sldc_pkg::MAIN_RECEIVER_DISABLE];
  wire repl_off  = ctrl_main[sldc_pkg::MAIN_REPL_OFF];
  wire srst      = ctrl_main[sldc_pkg::MAIN_SRST];
  wire force_req = ctrl_main[sldc_pkg::MAIN_FSYNC];
  wire frm_rep   = ctrl_main[sldc_pkg::MAIN_FRM_REP];
  wire qual      = ctrl_err[sldc_pkg::ERR_QUAL];
  wire alt_scr   = ctrl_err[sldc_pkg::ERR_ALT_SCR];
  wire post_sync_behaviour_sel   = ctrl_err[sldc_pkg::ERR_POST_SYNC_BEHAVIOUR_SEL];
  wire skip_alignment_sequence   = ctrl_err[sldc_pkg::ERR_SKIP_ALIGNMENT_SEQUENCE];
  wire fchk_sel  = ctrl_err[sldc_pkg::ERR_FCHK];
  wire perp      = ctrl_test[sldc_pkg::TEST_PERP];

  // Deframer state
  sldc_pkg::sldc_state_t state;
  sldc_pkg::sldc_state_t next_state;
  logic [2:0]  k_cnt;
  logic [2:0]  a_cnt;
  logic [2:0]  err_cnt;
  logic        prev_kk;
  logic        cfg_act;
  logic [3:0]  cfg_idx;
  logic [7:0]  cks_sum;
  logic        scr_on;
  logic [1:0]  uo_cnt;
  logic [14:0] scr_hist;
  logic [7:0]  last_oct;

  wire rx_ok  = rx_in.valid & ~receiver_disable; // [RULE1]
  wire disp_q = rx_in.disp_err & ~(qual & rx_in.nit_err); // [RULE7]
  wire is_kk  = rx_in.is_k & (rx_in.data == sldc_pkg::CHAR_K);
  wire is_kr  = rx_in.is_k & (rx_in.data == sldc_pkg::CHAR_R);
  wire is_a   = rx_in.is_k & (rx_in.data == sldc_pkg::CHAR_A);
  wire is_f   = rx_in.is_k & (rx_in.data == sldc_pkg::CHAR_F);
  wire is_q   = rx_in.is_k & (rx_in.data == sldc_pkg::CHAR_Q);
  wire synced = (state != sldc_pkg::SLDC_CGS);

  // Loss of sync after code group sync
  wire k_loss = post_sync_behaviour_sel & prev_kk & ~(is_kk | is_kr); // [RULE10]
  wire d_loss = ~post_sync_behaviour_sel & disp_q &
                (err_cnt == sldc_pkg::DISP_LOSS_COUNT - 3'h1); // [RULE9]
  wire loss   = rx_ok & synced & (k_loss | d_loss);

  wire cgs_done = rx_ok & is_kk &
                  (k_cnt == sldc_pkg::CGS_K_COUNT - 3'h1);
  wire ilas_end = rx_ok & is_a &
                  (a_cnt == sldc_pkg::ILAS_MF_COUNT - 3'h1);

  always_comb begin
    next_state = state;
    unique case (state)
      sldc_pkg::SLDC_CGS:
        if (cgs_done)
          next_state = skip_alignment_sequence ? sldc_pkg::SLDC_DATA
                               : sldc_pkg::SLDC_ILAS; // [RULE11]
      sldc_pkg::SLDC_ILAS:
        if (loss)
          next_state = sldc_pkg::SLDC_CGS;
        else if (ilas_end & ~perp)
          next_state = sldc_pkg::SLDC_DATA; // [RULE14]
      sldc_pkg::SLDC_DATA:
        if (loss)
          next_state = sldc_pkg::SLDC_CGS;
    endcase
    if (receiver_disable)
      next_state = sldc_pkg::SLDC_CGS; // [RULE1]
  end

  // Checksum of the configuration octets
  wire [7:0] cfg_add = fchk_sel ? rx_in.data
                       : sldc_field_sum(cfg_idx, rx_in.data); // [RULE13]
  wire cfg_take = rx_ok & cfg_act & (state == sldc_pkg::SLDC_ILAS);
  wire cks_last = cfg_take & (cfg_idx == sldc_pkg::CFG_CKS_IDX);
  wire cks_bad  = cks_last & (cks_sum != rx_in.data);

  // User data path
  wire [22:0] descr = sldc_descr(scr_hist, rx_in.data);
  wire scr_now = scr_on & (~alt_scr | uo_cnt == sldc_pkg::ALT_SCR_OCTET);
  wire [7:0] plain = scr_now ? descr[22:15] : rx_in.data; // [RULE8]
  wire in_data = rx_ok & (state == sldc_pkg::SLDC_DATA);
  wire end_chr = is_a | is_f;
  wire bad_oct = rx_in.nit_err | disp_q;
  wire unexp_k = in_data & rx_in.is_k & ~end_chr & ~is_kk;

  logic [7:0] next_oct;
  always_comb begin
    next_oct = plain;
    if (end_chr & ~repl_off)
      next_oct = last_oct; // [RULE3]
    else if (bad_oct & frm_rep)
      next_oct = last_oct; // [RULE6]
  end

  wire [sldc_pkg::IRQ_W-1:0] ev = {unexp_k,
                                   rx_ok & synced & disp_q,
                                   cks_bad,
                                   loss | (receiver_disable & synced)};

  // Bus slave: one wait cycle, then OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend      <= 1'b0;
      ap_write  <= 1'b0;
      ap_ok     <= 1'b0;
      ap_idx    <= 12'h000;
      hreadyout <= 1'b1;
      hrdata    <= 32'h00000000;
      hresp     <= 1'b0;
    end else begin
      pend      <= acc;
      hreadyout <= ~acc;
      if (acc) begin
        ap_write <= hwrite;
        ap_ok    <= dec_ok;
        ap_idx   <= haddr[13:2];
      end
      if (pend & ~ap_write)
        hrdata <= {24'h000000, rd_val};
      hresp <= 1'b0;
    end
  end

  // Control registers; configuration kept steady by software [RULE2]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_main <= sldc_pkg::MAIN_RST;
      ctrl_err  <= sldc_pkg::ERR_ILAS_RST;
      ctrl_test <= sldc_pkg::TEST_RST;
      irq_mask  <= sldc_pkg::IRQ_RST;
      irq_stat  <= sldc_pkg::IRQ_RST;
      irq       <= 1'b0;
    end else begin
      if (wr_main)
        ctrl_main <= hwdata[7:0] & sldc_pkg::MAIN_WMASK;
      if (wr_err)
        ctrl_err <= hwdata[7:0] & sldc_pkg::ERR_ILAS_WMASK;
      if (wr_test)
        ctrl_test <= hwdata[7:0] & sldc_pkg::TEST_WMASK;
      if (wr_mask)
        irq_mask <= hwdata[sldc_pkg::IRQ_W-1:0];
      irq_stat <= (irq_stat & ~(wr_stat ? hwdata[sldc_pkg::IRQ_W-1:0]
                                        : sldc_pkg::IRQ_RST)) | ev;
      irq <= |(irq_stat & irq_mask);
    end
  end

  // Deframer; soft reset holds it at power-on values, except sync_request_out, which follows the force bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state            <= sldc_pkg::SLDC_CGS;
      k_cnt            <= 3'h0;
      a_cnt            <= 3'h0;
      err_cnt          <= 3'h0;
      prev_kk          <= 1'b0;
      cfg_act          <= 1'b0;
      cfg_idx          <= 4'h0;
      cks_sum          <= 8'h00;
      scr_on           <= 1'b0;
      uo_cnt           <= 2'h0;
      scr_hist         <= 15'h0000;
      last_oct         <= 8'h00;
      init_sync        <= 1'b0;
      user_out         <= '0;
      sync_request_out <= 1'b0;
    end else if (srst) begin // [RULE4]
      state            <= sldc_pkg::SLDC_CGS;
      k_cnt            <= 3'h0;
      a_cnt            <= 3'h0;
      err_cnt          <= 3'h0;
      prev_kk          <= 1'b0;
      cfg_act          <= 1'b0;
      cfg_idx          <= 4'h0;
      cks_sum          <= 8'h00;
      scr_on           <= 1'b0;
      uo_cnt           <= 2'h0;
      scr_hist         <= 15'h0000;
      last_oct         <= 8'h00;
      init_sync        <= 1'b0;
      user_out         <= '0;
      sync_request_out <= force_req; // [RULE5]
    end else begin
      state <= next_state;
      sync_request_out <= force_req |
                          (next_state == sldc_pkg::SLDC_CGS); // [RULE5]
      if (rx_ok)
        prev_kk <= is_kk;
      if (state == sldc_pkg::SLDC_CGS) begin
        k_cnt   <= (rx_ok & is_kk) ? k_cnt + 3'h1 : 3'h0;
        a_cnt   <= 3'h0;
        err_cnt <= 3'h0;
        cfg_act <= 1'b0;
        cfg_idx <= 4'h0;
        cks_sum <= 8'h00;
        uo_cnt  <= 2'h0;
        if (cgs_done & skip_alignment_sequence)
          scr_on <= 1'b0;
      end else begin
        k_cnt <= 3'h0;
        if (rx_ok & disp_q & ~post_sync_behaviour_sel)
          err_cnt <= err_cnt + 3'h1; // [RULE9]
      end
      if (state == sldc_pkg::SLDC_ILAS & rx_ok) begin
        if (is_a)
          a_cnt <= ilas_end ? 3'h0 : a_cnt + 3'h1; // [RULE14]
        if (is_q) begin
          cfg_act <= 1'b1;
          cfg_idx <= 4'h0;
          cks_sum <= 8'h00;
        end else if (cfg_take) begin
          cfg_idx <= cfg_idx + 4'h1;
          cks_sum <= cks_sum + cfg_add;
          if (cfg_idx == sldc_pkg::CFG_SCR_IDX)
            scr_on <= rx_in.data[sldc_pkg::CFG_SCR_BIT];
          if (cks_last)
            cfg_act <= 1'b0;
        end
      end
      if (next_state == sldc_pkg::SLDC_CGS)
        init_sync <= 1'b0; // [RULE15]
      else if (ilas_end & state == sldc_pkg::SLDC_ILAS)
        init_sync <= 1'b1; // [RULE15]
      user_out.valid <= in_data & ~loss;
      if (in_data) begin
        if (uo_cnt != sldc_pkg::ALT_SCR_OCTET)
          uo_cnt <= uo_cnt + 2'h1;
        if (scr_on)
          scr_hist <= descr[14:0];
        last_oct      <= next_oct;
        user_out.data <= next_oct;
      end
    end
  end

endmodule

`default_nettype wire

// File: sldc_deframer_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sldc_deframer_ctrl_properties (
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic [31:0]         hwdata,
  input wire logic                hready,
  input wire logic [31:0]         hrdata,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire sldc_pkg::sldc_rx_t  rx_in,
  input wire sldc_pkg::sldc_out_t user_out,
  input wire logic                sync_request_out,
  input wire logic                irq
);
  logic        wr_q;
  logic [11:0] idx_q;
  logic [7:0]  main_r;
  logic [3:0]  mask_r;
  wire         acc = hsel && hready && htrans[1];
  wire         srst = main_r[3] && !main_r[2] && !main_r[7];
  wire         rxd = main_r[7] && !main_r[3];
  wire         aligned = haddr[31:14] == 18'h0 && haddr[1:0] == 2'h0;
  // Shadow of the main control and interrupt mask registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      idx_q  <= 12'h000;
      main_r <= sldc_pkg::MAIN_RST;
      mask_r <= 4'h0;
    end else begin
      wr_q  <= acc && hwrite && aligned;
      idx_q <= haddr[13:2];
      if (wr_q && idx_q == sldc_pkg::IDX_MAIN)
        main_r <= hwdata[7:0] & sldc_pkg::MAIN_WMASK;
      if (wr_q && idx_q == sldc_pkg::IDX_IRQ_MASK)
        mask_r <= hwdata[3:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_bus_one_wait: assert property (acc |=> !hreadyout ##1 hreadyout)
    else $error("bus wait state not one cycle");
  chk_rdata_upper: assert property (hrdata[31:8] == 24'h0 && !hresp)
    else $error("read upper bits or response wrong");
  chk_force_sync: assert property (
    main_r[2] [*2] |=> sync_request_out)
    else $error("force bit without sync request");
  chk_rxdis_sync: assert property (rxd [*2] |=> sync_request_out)
    else $error("disabled receiver without sync request");
  chk_rxdis_quiet: assert property (rxd [*2] |=> !user_out.valid)
    else $error("disabled receiver gave data");
  chk_srst_quiet: assert property (
    main_r[3] [*2] |=> !user_out.valid)
    else $error("data during soft reset");
  chk_srst_sync_off: assert property (
    srst [*2] |=> !sync_request_out)
    else $error("sync request during soft reset without force");
  chk_irq_masked: assert property ((mask_r == 4'h0) [*2] |-> !irq)
    else $error("interrupt while all masked");
  chk_out_has_input: assert property (
    user_out.valid |-> $past(rx_in.valid))
    else $error("user octet without received octet");
  cov_user_data: cover property (user_out.valid);
  cov_sync_drop: cover property ($fell(sync_request_out));
  cov_irq_high: cover property (irq);
endmodule

bind sldc_deframer_ctrl sldc_deframer_ctrl_properties
  sldc_deframer_ctrl_properties_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_in(rx_in),
  .user_out(user_out), .sync_request_out(sync_request_out), .irq(irq)
);
`default_nettype wire

// File: sldc_framer_model.sv
`timescale 1ns/1ps
`default_nettype none
module sldc_framer_model (
  input  wire logic              hclk,
  output var sldc_pkg::sldc_rx_t rx
);
  logic [7:0] last;
  initial begin
    last = 8'h00;
    rx = '0;
  end
  // One character per clock, launched just after the edge
  task automatic send(input logic [7:0] d, input logic k, n, e);
    @(posedge hclk);
    rx <= '{d, k, n, e, 1'b1};
    last = d;
  endtask
  // Released line shows the inverse of the last octet
  task automatic idle();
    @(posedge hclk);
    rx <= '{~last, 1'b0, 1'b0, 1'b0, 1'b0};
  endtask
  task automatic cgs();
    repeat (4) send(sldc_pkg::CHAR_K, 1'b1, 1'b0, 1'b0);
  endtask
  // Four multiframes, the second carrying the link parameters
  task automatic ilas(input logic [7:0] cks, input logic scr);
    for (int m = 0; m < 4; m++) begin
      send(sldc_pkg::CHAR_R, 1'b1, 1'b0, 1'b0);
      if (m == 1) begin
        send(sldc_pkg::CHAR_Q, 1'b1, 1'b0, 1'b0);
        for (int i = 0; i < 14; i++) begin
          send(i == 13 ? cks : (i == 3 ? {scr, 7'h00} : 8'h00),
               1'b0, 1'b0, 1'b0);
        end
      end
      send(sldc_pkg::CHAR_A, 1'b1, 1'b0, 1'b0);
    end
  endtask
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [31:0] A_SYNC = {18'h0, sldc_pkg::IDX_INIT_SYNC, 2'h0};
  localparam logic [31:0] A_MAIN = {18'h0, sldc_pkg::IDX_MAIN, 2'h0};
  localparam logic [31:0] A_ERR  = {18'h0, sldc_pkg::IDX_ERR_ILAS, 2'h0};
  localparam logic [31:0] A_TEST = {18'h0, sldc_pkg::IDX_TEST, 2'h0};
  localparam logic [31:0] A_STAT = {18'h0, sldc_pkg::IDX_IRQ_STAT, 2'h0};
  localparam logic [31:0] A_MASK = {18'h0, sldc_pkg::IDX_IRQ_MASK, 2'h0};
  logic                hclk;
  logic                hresetn;
  logic                hsel;
  logic [31:0]         haddr;
  logic [1:0]          htrans;
  logic                hwrite;
  logic [2:0]          hsize;
  logic [31:0]         hwdata;
  logic [31:0]         hrdata;
  logic                hreadyout;
  logic                hresp;
  sldc_pkg::sldc_rx_t  rx_in;
  sldc_pkg::sldc_out_t user_out;
  logic                sync_request_out;
  logic                irq;
  logic [31:0]         rd;
  logic [7:0]          got_q[$];
  int                  bad_count = 0;
  int                  n_checks = 0;
  sldc_deframer_ctrl sldc_deframer_ctrl_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_in(rx_in), .user_out(user_out),
    .sync_request_out(sync_request_out), .irq(irq)
  );
  sldc_framer_model sldc_framer_model_inst (.hclk(hclk), .rx(rx_in));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (user_out.valid === 1'b1)
      got_q.push_back(user_out.data);
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bit_chk(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask
  task automatic out_chk(input logic [7:0] e);
    if (got_q.size() == 0) check(32'hDEAD, {24'h0, e});
    else check({24'h0, got_q.pop_front()}, {24'h0, e});
  endtask
  // Single AHB transfer; read data taken when the data phase ends
  task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    bus(a, 1'b0, 8'h00);
    check(rd, e);
  endtask
  task automatic tx(input logic [7:0] d, input logic k, n, e);
    sldc_framer_model_inst.send(d, k, n, e);
  endtask
  task automatic settle();
    sldc_framer_model_inst.idle();
    repeat (3) @(posedge hclk);
  endtask
  task automatic t_regs();
    rdc(A_MAIN, 32'h01);
    rdc(A_ERR, 32'h14);
    wr(A_MAIN, 8'h09);
    wr(A_MAIN, 8'hFF);
    rdc(A_MAIN, 32'hCD);
    wr(A_TEST, 8'hFF);
    rdc(A_TEST, 32'h80);
    wr(A_SYNC, 8'hFF);
    rdc(A_SYNC, 32'h00);
    rdc(32'h0000_0100, 32'h00);
    wr(A_TEST, 8'h00);
    wr(A_MAIN, 8'h09);
    wr(A_MAIN, 8'h01);
    $display("test registers done");
  endtask
  task automatic t_link();
    got_q.delete();
    sldc_framer_model_inst.cgs();
    sldc_framer_model_inst.ilas(8'h00, 1'b0);
    tx(8'h11, 1'b0, 1'b0, 1'b0);
    tx(sldc_pkg::CHAR_F, 1'b1, 1'b0, 1'b0);
    tx(8'h22, 1'b0, 1'b1, 1'b0);
    tx(8'h33, 1'b0, 1'b0, 1'b0);
    settle();
    bit_chk(sync_request_out, 1'b0);
    rdc(A_SYNC, 32'h01);
    out_chk(8'h11);
    out_chk(8'h11);
    out_chk(8'h11);
    out_chk(8'h33);
    tx(sldc_pkg::CHAR_K, 1'b1, 1'b0, 1'b0);
    tx(8'h55, 1'b0, 1'b0, 1'b0);
    settle();
    bit_chk(sync_request_out, 1'b1);
    rdc(A_SYNC, 32'h00);
    bus(A_STAT, 1'b0, 8'h00);
    bit_chk(rd[0], 1'b1);
    bit_chk(irq, 1'b0);
    wr(A_MASK, 8'h01);
    @(posedge hclk);
    bit_chk(irq, 1'b1);
    wr(A_STAT, 8'h0F);
    @(posedge hclk);
    bit_chk(irq, 1'b0);
    wr(A_MASK, 8'h00);
    $display("test link done");
  endtask
  task automatic t_cfg();
    wr(A_MAIN, 8'h09);
    repeat (2) @(posedge hclk);
    bit_chk(sync_request_out, 1'b0);
    wr(A_ERR, 8'h19);
    wr(A_STAT, 8'h0F);
    wr(A_MAIN, 8'h01);
    got_q.delete();
    sldc_framer_model_inst.cgs();
    sldc_framer_model_inst.ilas(8'h80, 1'b1);
    settle();
    bus(A_STAT, 1'b0, 8'h00);
    bit_chk(rd[1], 1'b0);
    tx(8'hFF, 1'b0, 1'b0, 1'b0);
    tx(8'h00, 1'b0, 1'b0, 1'b0);
    tx(8'h00, 1'b0, 1'b0, 1'b0);
    settle();
    out_chk(8'hFF);
    out_chk(8'h00);
    out_chk(8'h02);
    $display("test checksum done");
  endtask
  task automatic t_skip();
    wr(A_MAIN, 8'h09);
    wr(A_MAIN, 8'h48);
    rdc(A_SYNC, 32'h00);
    wr(A_ERR, 8'h12);
    wr(A_MAIN, 8'h40);
    got_q.delete();
    sldc_framer_model_inst.cgs();
    tx(8'h11, 1'b0, 1'b0, 1'b0);
    tx(sldc_pkg::CHAR_F, 1'b1, 1'b0, 1'b0);
    tx(8'h22, 1'b0, 1'b1, 1'b0);
    settle();
    bit_chk(sync_request_out, 1'b0);
    out_chk(8'h11);
    out_chk(sldc_pkg::CHAR_F);
    out_chk(8'h22);
    wr(A_MAIN, 8'h44);
    repeat (2) @(posedge hclk);
    bit_chk(sync_request_out, 1'b1);
    wr(A_MAIN, 8'h40);
    repeat (2) @(posedge hclk);
    bit_chk(sync_request_out, 1'b0);
    tx(sldc_pkg::CHAR_K, 1'b1, 1'b0, 1'b0);
    tx(8'h55, 1'b0, 1'b0, 1'b0);
    repeat (4) tx(8'h00, 1'b0, 1'b1, 1'b1);
    repeat (3) tx(8'h00, 1'b0, 1'b0, 1'b1);
    settle();
    bit_chk(sync_request_out, 1'b0);
    tx(8'h00, 1'b0, 1'b0, 1'b1);
    settle();
    bit_chk(sync_request_out, 1'b1);
    $display("test skip done");
  endtask
  task automatic t_rxdis();
    wr(A_MAIN, 8'h48);
    wr(A_MAIN, 8'hC8);
    wr(A_MAIN, 8'hC0);
    got_q.delete();
    sldc_framer_model_inst.cgs();
    tx(8'h66, 1'b0, 1'b0, 1'b0);
    settle();
    bit_chk(sync_request_out, 1'b1);
    bit_chk(got_q.size() == 0, 1'b1);
    wr(A_MAIN, 8'hC8);
    wr(A_MAIN, 8'h48);
    wr(A_MAIN, 8'h40);
    sldc_framer_model_inst.cgs();
    tx(8'h66, 1'b0, 1'b0, 1'b0);
    settle();
    bit_chk(sync_request_out, 1'b0);
    out_chk(8'h66);
    $display("test receiver disable done");
  endtask
  task automatic t_perp();
    wr(A_MAIN, 8'h48);
    wr(A_ERR, 8'h14);
    wr(A_TEST, 8'h80);
    wr(A_STAT, 8'h0F);
    wr(A_MAIN, 8'h40);
    got_q.delete();
    sldc_framer_model_inst.cgs();
    sldc_framer_model_inst.ilas(8'h01, 1'b1);
    sldc_framer_model_inst.ilas(8'h01, 1'b1);
    tx(8'h77, 1'b0, 1'b0, 1'b0);
    settle();
    bit_chk(sync_request_out, 1'b0);
    bit_chk(got_q.size() == 0, 1'b1);
    bus(A_STAT, 1'b0, 8'h00);
    bit_chk(rd[1], 1'b0);
    $display("test perpetual alignment done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #60000;
    bad_count++;
    give_verdict();
  end
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, hresetn} = '0;
    hsize = 3'h2;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_link();
    t_cfg();
    t_skip();
    t_rxdis();
    t_perp();
    give_verdict();
  end
endmodule
`default_nettype wire
